// *** fpb_read_path.sv ***
// Read path of the flash array: page decode, two read page buffers, core fetch, write gating.
// Assumes the bus interface unit drives accesses and buffer loads synchronous to core_clk,
// and that the array core answers a page read with core_done after one or more cycles.
//
// What this block does
// - Array is eight 64-Kbyte blocks; two host a 16-Kbyte small block.
// - A seventeen-bit address locates each word of every array access.
// - Each read compares its 14-bit page tag with both buffer tags.
// - A hit skips the core and returns 64 bits from the buffer.
// - A miss reads a 32-byte page; only the addressed 64 bits return.
// - Array writes are ignored unless program or erase is in progress.
// - With shadow select at 1, array reads go to the shadow row; core writes carry no shadow flag.
// - Any shadow select change invalidates matching; next access misses.
// - Shadow row holds 512 bytes, addressed by low row and page bits.
// - Shadow row sits in the lowest block, inside its small block.
// - Small block 0 enabled: its guard and select bits govern shadow writes.
// - Small block 0 disabled: host block guard and select bits govern them.
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module fpb_read_path
  import fpb_pkg::*;
(
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  input  wire logic [fpb_pkg::REG_AW-1:0] reg_addr,
  input  wire logic [31:0]               reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [31:0]               reg_rdata,
  input  wire logic                      acc_valid,
  input  wire fpb_pkg::fpb_acc_type      acc,
  output logic                           acc_ready,
  output logic                           resp_valid,
  output fpb_pkg::fpb_resp_type          resp,
  output logic      [fpb_pkg::PAGE_W-1:0] fetch_page,
  input  wire logic                      buf_load,
  input  wire logic                      buf_index,
  output logic                           core_rd,
  output fpb_pkg::fpb_core_addr_type     core_addr,
  input  wire logic                      core_done,
  input  wire logic [fpb_pkg::PAGE_W-1:0] core_data,
  output logic                           core_wr,
  output logic      [fpb_pkg::ADDR_W-1:0] core_wr_addr,
  output logic      [31:0]               core_wr_data
);
  import fpb_pkg::*;

  typedef enum logic [0:0] {ST_IDLE, ST_FETCH} fpb_state_type;

  fpb_state_type                state_q, state_d;
  logic [31:0]                  config_q, config_d;
  logic [31:0]                  guard_q, guard_d;
  logic [31:0]                  rdata_q, rdata_d;
  logic [NUM_BUF-1:0]           valid_q, valid_d;
  logic [TAG_W-1:0]             tag_q [NUM_BUF];
  logic [TAG_W-1:0]             tag_d [NUM_BUF];
  logic [PAGE_W-1:0]            page_q [NUM_BUF];
  logic [PAGE_W-1:0]            page_d [NUM_BUF];
  logic [PAGE_W-1:0]            fetch_q, fetch_d;
  logic [TAG_W-1:0]             fetch_tag_q, fetch_tag_d;
  logic [1:0]                   fetch_sel_q, fetch_sel_d;
  logic                         fetch_ok_q, fetch_ok_d;
  logic                         ready_q, ready_d;
  logic                         rvalid_q, rvalid_d;
  fpb_resp_type                 resp_q, resp_d;
  logic                         crd_q, crd_d;
  fpb_core_addr_type            caddr_q, caddr_d;
  logic                         cwr_q, cwr_d;
  logic [ADDR_W-1:0]            cwaddr_q, cwaddr_d;
  logic [31:0]                  cwdata_q, cwdata_d;
  logic                         hit_flag_q, hit_flag_d;
  logic                         miss_flag_q, miss_flag_d;
  logic                         wdrop_q, wdrop_d;

  logic [NUM_BUF-1:0]           match;
  logic [TAG_W-1:0]             acc_tag;
  logic [1:0]                   acc_sel;
  logic [2:0]                   acc_block;
  logic                         shadow_sel;
  logic                         pe_active;
  logic [NUM_SMALL-1:0]         sb_enable;
  logic [NUM_SMALL-1:0]         sb_guard;
  logic [NUM_SMALL-1:0]         sb_select;
  logic [NUM_BLOCK-1:0]         blk_select;
  logic [NUM_BLOCK-1:0]         blk_guard;
  logic                         in_small0;
  logic                         in_small1;
  logic                         write_ok;

  assign shadow_sel = config_q[CFG_SHADOW_BIT];
  assign pe_active  = config_q[CFG_PE_BIT];
  assign sb_enable  = config_q[CFG_SMALL_BLOCK_ENABLE_LSB +: NUM_SMALL];
  assign sb_guard   = config_q[CFG_SBGRD_LSB +: NUM_SMALL];
  assign sb_select  = config_q[CFG_SBSEL_LSB +: NUM_SMALL];
  assign blk_select = guard_q[GRD_SEL_LSB +: NUM_BLOCK];
  assign blk_guard  = guard_q[GRD_PROT_LSB +: NUM_BLOCK];

  // In the shadow row only the low row and page bits take part.
  always_comb
  begin
    acc_tag   = acc.addr[ADDR_W-1:TAG_LSB];
    acc_sel   = acc.addr[TAG_LSB-1:DW_SEL_LSB];
    acc_block = acc.addr[ADDR_W-1:BLOCK_LSB];
    if (shadow_sel)
    begin
      acc_tag = {{(TAG_W-SHADOW_TAG_W){1'b0}}, acc.addr[TAG_LSB +: SHADOW_TAG_W]};
      // Shadow row lives in the lowest block.
      acc_block = SMALL0_HOST;
    end
  end

  // Small blocks are the lowest 16 Kbytes of their host blocks.
  assign in_small0 = (acc_block == SMALL0_HOST) && (acc.addr[BLOCK_LSB-1:SMALL_LSB] == 2'h0);
  assign in_small1 = (acc_block == SMALL1_HOST) && (acc.addr[BLOCK_LSB-1:SMALL_LSB] == 2'h0);

  // Write permission: selected and unprotected, small block bits override when enabled.
  always_comb
  begin
    write_ok = blk_select[acc_block] && !blk_guard[acc_block];
    if (shadow_sel)
    begin
      // Small block 0 bits govern the shadow row.
      if (sb_enable[0])
        write_ok = sb_select[0] && !sb_guard[0];
      // Otherwise the host block bits govern it.
      else
        write_ok = blk_select[SMALL0_HOST] && !blk_guard[SMALL0_HOST];
    end
    else if (in_small0 && sb_enable[0])
      write_ok = sb_select[0] && !sb_guard[0];
    else if (in_small1 && sb_enable[1])
      write_ok = sb_select[1] && !sb_guard[1];
  end

  // Tag compare against both page buffers.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BUF; gi++)
    begin : g_match
      assign match[gi] = valid_q[gi] && (tag_q[gi] == acc_tag);
    end
  endgenerate

  always_comb
  begin
    state_d     = state_q;
    config_d    = config_q;
    guard_d     = guard_q;
    rdata_d     = 32'h0000_0000;
    valid_d     = valid_q;
    tag_d       = tag_q;
    page_d      = page_q;
    fetch_d     = fetch_q;
    fetch_tag_d = fetch_tag_q;
    fetch_sel_d = fetch_sel_q;
    fetch_ok_d  = fetch_ok_q;
    ready_d     = ready_q;
    rvalid_d    = 1'b0;
    resp_d      = resp_q;
    crd_d       = 1'b0;
    caddr_d     = caddr_q;
    cwr_d       = 1'b0;
    cwaddr_d    = cwaddr_q;
    cwdata_d    = cwdata_q;
    hit_flag_d  = hit_flag_q;
    miss_flag_d = miss_flag_q;
    wdrop_d     = wdrop_q;

    if (reg_rd)
    begin
      case (reg_addr)
        CONFIG_OFS: rdata_d = config_q;
        GUARD_OFS:  rdata_d = guard_q;
        STATUS_OFS:
        begin
          rdata_d[ST_VALID_LSB +: NUM_BUF] = valid_q;
          rdata_d[ST_HIT_BIT]              = hit_flag_q;
          rdata_d[ST_MISS_BIT]             = miss_flag_q;
          rdata_d[ST_WDROP_BIT]            = wdrop_q;
          rdata_d[ST_BUSY_BIT]             = (state_q == ST_FETCH);
        end
        default: rdata_d = 32'h0000_0000;
      endcase
    end

    // The bus interface unit chooses the buffer for the last fetched page.
    if (buf_load && fetch_ok_q)
    begin
      page_d[buf_index]  = fetch_q;
      tag_d[buf_index]   = fetch_tag_q;
      valid_d[buf_index] = 1'b1;
    end

    case (state_q)
      ST_IDLE:
      begin
        if (acc_valid && acc.write)
        begin
          // Writes reach the core only during program or erase.
          if (pe_active && write_ok)
          begin
            cwr_d    = 1'b1;
            cwaddr_d = acc.addr;
            cwdata_d = acc.wdata;
          end
          else
            wdrop_d = 1'b1;
        end
        else if (acc_valid && (|match))
        begin
          // Hit answers from the buffer without a core read.
          rvalid_d     = 1'b1;
          resp_d.hit   = 1'b1;
          resp_d.data  = page_q[match[1] ? 1 : 0][acc_sel*DWORD_W +: DWORD_W];
          hit_flag_d   = 1'b1;
        end
        else if (acc_valid)
        begin
          // Miss starts a page read from the core.
          // Shadow select steers the core read to the shadow row.
          crd_d          = 1'b1;
          caddr_d.shadow = shadow_sel;
          caddr_d.page   = acc_tag;
          fetch_tag_d    = acc_tag;
          fetch_sel_d    = acc_sel;
          fetch_ok_d     = 1'b0;
          ready_d        = 1'b0;
          miss_flag_d    = 1'b1;
          state_d        = ST_FETCH;
        end
      end
      ST_FETCH:
      begin
        if (core_done)
        begin
          // Only the addressed 64 bits go back.
          fetch_d     = core_data;
          fetch_ok_d  = (caddr_q.shadow == shadow_sel);
          rvalid_d    = 1'b1;
          resp_d.hit  = 1'b0;
          resp_d.data = core_data[fetch_sel_q*DWORD_W +: DWORD_W];
          ready_d     = 1'b1;
          state_d     = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase

    if (reg_wr)
    begin
      case (reg_addr)
        CONFIG_OFS:
        begin
          config_d = reg_wdata;
          // A shadow select change forces the next access to miss.
          if (reg_wdata[CFG_SHADOW_BIT] != shadow_sel)
          begin
            valid_d    = '0;
            fetch_ok_d = 1'b0;
          end
        end
        GUARD_OFS: guard_d = reg_wdata;
        STATUS_OFS:
        begin
          // Write one to clear; an event in the same cycle wins.
          if (reg_wdata[ST_HIT_BIT] && !(rvalid_d && resp_d.hit))
            hit_flag_d = 1'b0;
          if (reg_wdata[ST_MISS_BIT] && !crd_d)
            miss_flag_d = 1'b0;
          if (reg_wdata[ST_WDROP_BIT] && !(acc_valid && acc.write && !cwr_d
              && state_q == ST_IDLE))
            wdrop_d = 1'b0;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q     <= ST_IDLE;
      config_q    <= CONFIG_RESET;
      guard_q     <= GUARD_RESET;
      rdata_q     <= 32'h0000_0000;
      valid_q     <= '0;
      tag_q       <= '{default: '0};
      page_q      <= '{default: '0};
      fetch_q     <= '0;
      fetch_tag_q <= '0;
      fetch_sel_q <= 2'h0;
      fetch_ok_q  <= 1'b0;
      ready_q     <= 1'b1;
      rvalid_q    <= 1'b0;
      resp_q      <= '0;
      crd_q       <= 1'b0;
      caddr_q     <= '0;
      cwr_q       <= 1'b0;
      cwaddr_q    <= '0;
      cwdata_q    <= 32'h0000_0000;
      hit_flag_q  <= 1'b0;
      miss_flag_q <= 1'b0;
      wdrop_q     <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      config_q    <= config_d;
      guard_q     <= guard_d;
      rdata_q     <= rdata_d;
      valid_q     <= valid_d;
      tag_q       <= tag_d;
      page_q      <= page_d;
      fetch_q     <= fetch_d;
      fetch_tag_q <= fetch_tag_d;
      fetch_sel_q <= fetch_sel_d;
      fetch_ok_q  <= fetch_ok_d;
      ready_q     <= ready_d;
      rvalid_q    <= rvalid_d;
      resp_q      <= resp_d;
      crd_q       <= crd_d;
      caddr_q     <= caddr_d;
      cwr_q       <= cwr_d;
      cwaddr_q    <= cwaddr_d;
      cwdata_q    <= cwdata_d;
      hit_flag_q  <= hit_flag_d;
      miss_flag_q <= miss_flag_d;
      wdrop_q     <= wdrop_d;
    end
  end

  assign reg_rdata    = rdata_q;
  assign acc_ready    = ready_q;
  assign resp_valid   = rvalid_q;
  assign resp         = resp_q;
  assign fetch_page   = fetch_q;
  assign core_rd      = crd_q;
  assign core_addr    = caddr_q;
  assign core_wr      = cwr_q;
  assign core_wr_addr = cwaddr_q;
  assign core_wr_data = cwdata_q;

endmodule

`default_nettype wire

// *** fpb_pkg.sv ***
// Package for the flash page buffer read path: field layouts, offsets, reset values, carriers.
// Assumes one system clock; every user of it imports the whole package.
package fpb_pkg;

  localparam int ADDR_W      = 17;
  localparam int TAG_W       = 14;
  localparam int TAG_LSB     = 3;
  localparam int DW_SEL_LSB  = 1;
  localparam int PAGE_W      = 256;
  localparam int DWORD_W     = 64;
  localparam int NUM_BUF     = 2;
  localparam int NUM_BLOCK   = 8;
  localparam int NUM_SMALL   = 2;
  localparam int BLOCK_LSB   = 14;
  localparam int SMALL_LSB   = 12;
  localparam int SHADOW_TAG_W = 4;

  // Block size, small block size and shadow row size in bytes.
  localparam int BLOCK_BYTES  = 65536;
  localparam int SMALL_BYTES  = 16384;
  localparam int SHADOW_BYTES = 512;

  // Host block of each small block; each small block is the lowest 16 Kbytes of its host.
  localparam logic [2:0] SMALL0_HOST = 3'h0;
  localparam logic [2:0] SMALL1_HOST = 3'h1;

  localparam int          REG_AW       = 8;
  localparam logic [7:0]  CONFIG_OFS   = 8'h00;
  localparam logic [7:0]  GUARD_OFS    = 8'h04;
  localparam logic [7:0]  STATUS_OFS   = 8'h08;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
  localparam logic [31:0] GUARD_RESET  = 32'h0000_FF00;

  // Configuration register fields.
  localparam int CFG_SHADOW_BIT = 0;
  localparam int CFG_SMALL_BLOCK_ENABLE_LSB   = 4;
  localparam int CFG_SBGRD_LSB  = 8;
  localparam int CFG_SBSEL_LSB  = 12;
  localparam int CFG_PE_BIT     = 16;
  // Guard register fields.
  localparam int GRD_SEL_LSB    = 0;
  localparam int GRD_PROT_LSB   = 8;
  // Status register fields.
  localparam int ST_VALID_LSB   = 0;
  localparam int ST_HIT_BIT     = 4;
  localparam int ST_MISS_BIT    = 5;
  localparam int ST_WDROP_BIT   = 6;
  localparam int ST_BUSY_BIT    = 7;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
  } fpb_acc_type;

  typedef struct packed {
    logic               hit;
    logic [DWORD_W-1:0] data;
  } fpb_resp_type;

  typedef struct packed {
    logic             shadow;
    logic [TAG_W-1:0] page;
  } fpb_core_addr_type;

endpackage

// *** fpb_read_path_props.sv ***
// Checker for the flash read path, watching only its top-level ports.
// Assumes one core_clk domain and the active-high asynchronous rst.
`timescale 1ns/1ps
`default_nettype none
module fpb_read_path_props
  import fpb_pkg::*;
(
  input wire logic                       core_clk,
  input wire logic                       rst,
  input wire logic                       acc_valid,
  input wire fpb_pkg::fpb_acc_type       acc,
  input wire logic                       acc_ready,
  input wire logic                       resp_valid,
  input wire fpb_pkg::fpb_resp_type      resp,
  input wire logic                       core_rd,
  input wire fpb_pkg::fpb_core_addr_type core_addr,
  input wire logic                       core_done,
  input wire logic                       core_wr,
  input wire logic [fpb_pkg::ADDR_W-1:0] core_wr_addr,
  input wire logic [31:0]                core_wr_data
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic take;
  assign take = acc_valid && acc_ready;
  sequence s_rd_take;
    take && !acc.write;
  endsequence
  sequence s_fetch;
    core_rd ##1 !acc_ready;
  endsequence
  property p_read_answer;
    s_rd_take |=> core_rd != (resp_valid && resp.hit);
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read neither served nor fetched");
  property p_hit_no_core;
    resp_valid && resp.hit |-> !core_rd && $past(take);
  endproperty
  a_hit_no_core: assert property (p_hit_no_core)
    else $error("hit without request or with core read");
  property p_core_src;
    core_rd |-> $past(take) && !$past(acc.write);
  endproperty
  a_core_src: assert property (p_core_src)
    else $error("core read without a taken read");
  property p_miss_hold;
    s_rd_take ##1 core_rd |-> s_fetch;
  endproperty
  a_miss_hold: assert property (p_miss_hold)
    else $error("ready during fetch");
  property p_done_resp;
    core_done |=> resp_valid && !resp.hit && acc_ready;
  endproperty
  a_done_resp: assert property (p_done_resp)
    else $error("no miss answer after core done");
  property p_page_addr;
    core_rd && !core_addr.shadow |-> core_addr.page == $past(acc.addr[16:3]);
  endproperty
  a_page_addr: assert property (p_page_addr)
    else $error("core page differs from address");
  property p_shadow_addr;
    core_rd && core_addr.shadow |-> core_addr.page == {10'h000, $past(acc.addr[6:3])};
  endproperty
  a_shadow_addr: assert property (p_shadow_addr)
    else $error("shadow page not from low bits");
  property p_wr_src;
    core_wr |-> $past(take) && $past(acc.write) && core_wr_addr == $past(acc.addr)
      && core_wr_data == $past(acc.wdata);
  endproperty
  a_wr_src: assert property (p_wr_src)
    else $error("core write not from a taken write");
  property p_idle_reset;
    $fell(rst) |-> acc_ready && !resp_valid && !core_rd && !core_wr;
  endproperty
  a_idle_reset: assert property (p_idle_reset)
    else $error("not idle after reset");
endmodule
bind fpb_read_path fpb_read_path_props i_props (.core_clk(core_clk), .rst(rst),
  .acc_valid(acc_valid), .acc(acc), .acc_ready(acc_ready), .resp_valid(resp_valid),
  .resp(resp), .core_rd(core_rd), .core_addr(core_addr), .core_done(core_done),
  .core_wr(core_wr), .core_wr_addr(core_wr_addr), .core_wr_data(core_wr_data));
`default_nettype wire

// *** fpb_biu_model.sv ***
// Model of the bus interface unit and array core beside the read path.
// Assumes one core_rd pulse per fetch; answers after a chosen latency.
`timescale 1ns/1ps
`default_nettype none
module fpb_biu_model
  import fpb_pkg::*;
(
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  input  wire logic                       core_rd,
  input  wire fpb_pkg::fpb_core_addr_type core_addr,
  input  wire logic                       resp_valid,
  input  wire fpb_pkg::fpb_resp_type      resp,
  input  wire logic                       update,
  input  wire logic                       victim,
  input  wire logic [2:0]                 lat,
  output logic                            core_done,
  output logic [fpb_pkg::PAGE_W-1:0]      core_data,
  output logic                            buf_load,
  output logic                            buf_index
);
  logic [2:0]   cnt;
  logic         busy;
  logic [255:0] page;
  // Data lines show the inverse page outside the done cycle.
  assign core_data = core_done ? page : ~page;
  // model never fetches code through the block
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt <= 3'h0;
      busy <= 1'b0;
      page <= '0;
      core_done <= 1'b0;
      buf_load <= 1'b0;
      buf_index <= 1'b0;
    end
    else
    begin
      core_done <= busy && cnt == 3'h0;
      if (core_rd)
      begin
        busy <= 1'b1;
        cnt <= lat;
        for (int s = 0; s < 4; s++)
          page[64*s +: 64] <= {core_addr.shadow, core_addr.page, 2'(s), 47'h0};
      end
      else if (busy)
      begin
        busy <= cnt != 3'h0;
        cnt <= cnt - 3'h1;
      end
      buf_load <= resp_valid && !resp.hit && update;
      buf_index <= victim;
    end
  end
endmodule
`default_nettype wire

// *** fpb_read_path_tb.sv ***
// Testbench for the flash read path with the bus interface unit model.
// Assumes a 10 MHz core_clk; expected answers are queued and checked as they appear.
`timescale 1ns/1ps
`default_nettype none
module fpb_read_path_tb;
  import fpb_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, acc_valid = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, core_wr_data, seed = 32'hB6CC6395;
  fpb_acc_type acc = '0;
  fpb_resp_type resp, e, qs[$];
  fpb_core_addr_type core_addr;
  logic [255:0] fetch_page, core_data;
  logic [16:0] core_wr_addr, pa, pb, x;
  logic acc_ready, resp_valid, buf_load, buf_index, core_rd, core_done, core_wr;
  logic update = 1'b1, victim = 1'b0, rd_pend = 1'b0;
  logic [2:0] lat = 3'h0;
  logic [31:0] rq[$];
  int fails = 0, checks = 0, wr_n = 0;
  fpb_read_path i_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .acc_valid(acc_valid), .acc(acc), .acc_ready(acc_ready), .resp_valid(resp_valid),
    .resp(resp), .fetch_page(fetch_page), .buf_load(buf_load), .buf_index(buf_index),
    .core_rd(core_rd), .core_addr(core_addr), .core_done(core_done),
    .core_data(core_data), .core_wr(core_wr), .core_wr_addr(core_wr_addr),
    .core_wr_data(core_wr_data));
  fpb_biu_model i_biu (.core_clk(core_clk), .rst(rst), .core_rd(core_rd),
    .core_addr(core_addr), .resp_valid(resp_valid), .resp(resp), .update(update),
    .victim(victim), .lat(lat), .core_done(core_done), .core_data(core_data),
    .buf_load(buf_load), .buf_index(buf_index));
  always #50 core_clk = ~core_clk;
  task automatic check(input logic [64:0] seen, input logic [64:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  always @(posedge core_clk)
  begin
    if (rd_pend)
      check(65'(reg_rdata), 65'(rq.pop_front()));
    rd_pend <= reg_rd;
    if (resp_valid)
    begin
      e = qs.pop_front();
      check(resp, e);
      if (!e.hit)
        check(65'(fetch_page[255:192]), {1'b0, e[63:49], 2'h3, 47'h0});
    end
    if (core_wr)
      wr_n++;
  end
  task automatic rw(input logic [7:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rr(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [16:0] a, input logic h, input logic sh);
    logic [13:0] t;
    t = sh ? {10'h000, a[6:3]} : a[16:3];
    qs.push_back({h, sh, t, a[2:1], 47'h0});
    lat <= 3'($random(seed));
    acc_valid <= 1'b1;
    acc <= '{1'b0, a, 32'h0};
    do @(posedge core_clk); while (acc_ready !== 1'b1);
  endtask
  task automatic wr(input logic [16:0] a);
    acc_valid <= 1'b1;
    acc <= '{1'b1, a, 32'($random(seed))};
    do @(posedge core_clk); while (acc_ready !== 1'b1);
    acc_valid <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic idle();
    int n;
    n = 0;
    acc_valid <= 1'b0;
    while (qs.size() != 0 && n < 40)
    begin
      @(posedge core_clk);
      n++;
    end
    repeat (3) @(posedge core_clk);
  endtask
  task automatic summarize();
    fails += qs.size();
    if (fails == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    #2000000;
    fails++;
    summarize();
  end
  initial
  begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    pa = 17'($random(seed));
    pb = pa ^ 17'h00008;
    x = 17'($random(seed));
    rr(STATUS_OFS, 32'h0);
    rr(CONFIG_OFS, CONFIG_RESET);
    rr(GUARD_OFS, GUARD_RESET);
    rr(8'h0C, 32'h0);
    rd({pa[16:3], 2'h1, pa[0]}, 1'b0, 1'b0);
    idle();
    rd({pa[16:3], 2'h3, pa[0]}, 1'b1, 1'b0);
    idle();
    update <= 1'b0;
    rd({pb[16:3], 2'h0, pb[0]}, 1'b0, 1'b0);
    idle();
    rd({pb[16:3], 2'h2, pb[0]}, 1'b0, 1'b0);
    idle();
    update <= 1'b1;
    victim <= 1'b1;
    rd({pb[16:3], 2'h1, pb[0]}, 1'b0, 1'b0);
    idle();
    rd({pa[16:3], 2'h0, pa[0]}, 1'b1, 1'b0);
    rd({pb[16:3], 2'h3, pb[0]}, 1'b1, 1'b0);
    idle();
    rr(STATUS_OFS, 32'h33);
    rw(STATUS_OFS, 32'h70);
    rr(STATUS_OFS, 32'h03);
    wr(pa);
    rr(STATUS_OFS, 32'h43);
    rw(STATUS_OFS, 32'h70);
    rw(GUARD_OFS, 32'h0000FB04);
    rw(CONFIG_OFS, 32'h00010000);
    wr({3'h2, x[13:0]});
    wr({3'h3, x[13:0]});
    rw(CONFIG_OFS, 32'h00011011);
    rr(STATUS_OFS, 32'h40);
    wr({5'h00, x[11:0]});
    rd(x, 1'b0, 1'b1);
    idle();
    rw(CONFIG_OFS, 32'h00011001);
    wr({5'h00, x[11:0]});
    rw(CONFIG_OFS, 32'h0);
    rd({pa[16:3], 2'h2, pa[0]}, 1'b0, 1'b0);
    idle();
    rd({pb[16:3], 2'h1, pb[0]}, 1'b0, 1'b0);
    rw(CONFIG_OFS, 32'h00000001);
    idle();
    rr(STATUS_OFS, 32'h60);
    check(65'(wr_n), 65'h2);
    summarize();
  end
endmodule
`default_nettype wire
